//--- logic/csie_params.svh
// Constants for the special instruction execution unit.
// Assumes inclusion by the package and the core module only.
`ifndef CSIE_PARAMS_SVH
`define CSIE_PARAMS_SVH
`define CSIE_NIB_W     4
`define CSIE_BIT_W     2
`define CSIE_ADDR_W    12
`define CSIE_NIB_ZERO  4'h0
`define CSIE_ALL_ONES  4'hF
`define CSIE_SKIP_CYC  1
`define CSIE_PTR_RST   8'h00
`define CSIE_ADDR_RST  12'h000
`define CSIE_ADDR_STEP 12'h001
`define CSIE_BIT_ONE   4'h1
`define CSIE_LO_MSB    3
`define CSIE_HI_LSB    4
`define CSIE_HI_MSB    7
`endif

//--- logic/csie_pkg.sv
// Types for the special instruction execution unit.
// Assumes csie_params.svh is on the include path.
`include "csie_params.svh"
package csie_pkg;
    // Decoded operation codes handed in by the fetch stage
    typedef enum logic [3:0] {
        CSIE_OP_NONE        = 4'h0,
        CSIE_OP_BIT_SET     = 4'h1,
        CSIE_OP_BIT_CLEAR   = 4'h2,
        CSIE_OP_SKIP_TRUE   = 4'h3,
        CSIE_OP_SKIP_FALSE  = 4'h4,
        CSIE_OP_SKIP_TCLR   = 4'h5,
        CSIE_OP_CARRY_AND   = 4'h6,
        CSIE_OP_CARRY_OR    = 4'h7,
        CSIE_OP_CARRY_XOR   = 4'h8,
        CSIE_OP_LOAD_ACC    = 4'h9,
        CSIE_OP_LOAD_WIDE   = 4'hA,
        CSIE_OP_LOAD_PTR    = 4'hB,
        CSIE_OP_ADD_SKIP    = 4'hC,
        CSIE_OP_ADD_CARRY   = 4'hD,
        CSIE_OP_OTHER       = 4'hE
    } csie_op_e;
    // Chain groups of constant loads
    typedef enum logic [2:0] {
        CSIE_CH_NONE = 3'b001,
        CSIE_CH_ACC  = 3'b010,
        CSIE_CH_PTR  = 3'b100
    } csie_chain_e;
    typedef logic [`CSIE_NIB_W-1:0] csie_nib_t;
endpackage

//--- logic/csie_core.sv
// Executes bit, chained-load and base-correction instructions of a 4-bit core.
// Assumes a fetch stage presents one decoded op per valid cycle and writes back
// bit/memory results through the mem write port; skip_out squashes the next op.
`include "csie_params.svh"

// Overview of operation
// - Bit set, clear, test-skip, test-clear and carry AND/OR/XOR act on the addressed bit.
// - The same bit operations work on port bits, since ports share the bit address space.
// - Accumulator loads and pointer loads at contiguous addresses form chains.
// - Only the first load of a chain takes effect; later members are no-operations.
// - Base correction add_immediate_with_skip 16-m, then memory plus carry, then m to the accumulator.
// - A carry from the memory add-with-carry skips the following immediate add.
// - Without that carry the following immediate add executes normally.
// - That immediate add never skips on its own carry after a memory add-with-carry.
// - Overflow of the corrected digit stays in the carry flag.
// - A met skip condition bypasses the next instruction.
// - A skip costs one machine cycle, equal to one clock period.
module csie_core (
    // Clock, reset, enable
    input  wire logic               ref_clk_in,
    input  wire logic               reset_n_in,
    input  wire logic               clk_en_in,
    // Decoded instruction from fetch
    input  wire logic               op_valid_in,
    input  wire csie_pkg::csie_op_e op_in,
    input  wire logic [11:0]        op_addr_in,
    input  wire logic [1:0]         bit_sel_in,
    input  wire logic [7:0]         imm_in,
    // Addressed memory or port nibble, read data
    input  wire logic [3:0]         mem_rdata_in,
    // Memory/port write back
    output logic                    mem_we_out,
    output logic [3:0]              mem_wdata_out,
    // Architectural registers
    output logic [3:0]              acc_out,
    output logic [3:0]              wide_hi_out,
    output logic [7:0]              data_pointer_pair_out,
    output logic                    carry_flag_out,
    // Sequencing
    output logic                    skip_out,
    output logic                    nop_out
);
    import csie_pkg::*;

    logic [3:0]  acc, next_acc;
    logic [3:0]  wide_hi, next_wide_hi;
    logic [7:0]  ptr, next_ptr;
    logic        carry_flag, next_carry_flag;
    logic        skip_pend, next_skip_pend;
    logic        after_add_with_carry_memory, next_after_add_with_carry_memory;
    logic        mem_we, next_mem_we;
    logic [3:0]  mem_wdata, next_mem_wdata;
    logic [11:0] last_addr, next_last_addr;
    csie_chain_e chain, next_chain;
    csie_chain_e op_chain;
    logic        bitv;
    logic [4:0]  sum;
    logic        in_chain;

    // Which chain group the current op belongs to
    always_comb begin
        unique case (op_in)
            CSIE_OP_LOAD_ACC, CSIE_OP_LOAD_WIDE: op_chain = CSIE_CH_ACC;
            CSIE_OP_LOAD_PTR:                    op_chain = CSIE_CH_PTR;
            default:                             op_chain = CSIE_CH_NONE;
        endcase
    end

    // Next-state of all architectural and sequencing state
    always_comb begin
        next_acc        = acc;
        next_wide_hi    = wide_hi;
        next_ptr        = ptr;
        next_carry_flag = carry_flag;
        next_skip_pend  = skip_pend;
        next_after_add_with_carry_memory = after_add_with_carry_memory;
        next_mem_we     = 1'b0;
        next_mem_wdata  = mem_wdata;
        next_last_addr  = last_addr;
        next_chain      = chain;
        bitv            = mem_rdata_in[bit_sel_in];
        sum             = 5'h00;
        in_chain        = 1'b0;
        if (op_valid_in) begin
            next_last_addr = op_addr_in;
            // Contiguous member of the same chain group
            in_chain = (op_chain != CSIE_CH_NONE) && (op_chain == chain)
                       && (op_addr_in == last_addr + `CSIE_ADDR_STEP);
            if (skip_pend) begin
                // Skipped slot: one cycle, no effect, breaks any chain
                next_skip_pend  = 1'b0;
                next_after_add_with_carry_memory = 1'b0;
                next_chain      = CSIE_CH_NONE;
            end else begin
                next_chain      = op_chain;
                next_after_add_with_carry_memory = 1'b0;
                unique case (op_in)
                    // Ports sit in the same bit space, so no special path
                    CSIE_OP_BIT_SET: begin
                        next_mem_we    = 1'b1;
                        next_mem_wdata = mem_rdata_in | (`CSIE_BIT_ONE << bit_sel_in);
                    end
                    CSIE_OP_BIT_CLEAR: begin
                        next_mem_we    = 1'b1;
                        next_mem_wdata = mem_rdata_in & ~(`CSIE_BIT_ONE << bit_sel_in);
                    end
                    CSIE_OP_SKIP_TRUE:  next_skip_pend = bitv;
                    CSIE_OP_SKIP_FALSE: next_skip_pend = ~bitv;
                    CSIE_OP_SKIP_TCLR: begin
                        next_skip_pend = bitv;
                        next_mem_we    = 1'b1;
                        next_mem_wdata = mem_rdata_in & ~(`CSIE_BIT_ONE << bit_sel_in);
                    end
                    CSIE_OP_CARRY_AND: next_carry_flag = carry_flag & bitv;
                    CSIE_OP_CARRY_OR:  next_carry_flag = carry_flag | bitv;
                    CSIE_OP_CARRY_XOR: next_carry_flag = carry_flag ^ bitv;
                    CSIE_OP_LOAD_ACC: begin
                        if (!in_chain) next_acc = imm_in[`CSIE_LO_MSB:0];
                    end
                    CSIE_OP_LOAD_WIDE: begin
                        if (!in_chain) begin
                            next_acc     = imm_in[`CSIE_LO_MSB:0];
                            next_wide_hi = imm_in[`CSIE_HI_MSB:`CSIE_HI_LSB];
                        end
                    end
                    CSIE_OP_LOAD_PTR: begin
                        if (!in_chain) next_ptr = imm_in;
                    end
                    CSIE_OP_ADD_SKIP: begin
                        // Immediate add: carry not stored, skip on carry unless
                        // it follows add-with-carry, so overflow stays in carry
                        sum            = {1'b0, acc} + {1'b0, imm_in[`CSIE_LO_MSB:0]};
                        next_acc       = sum[3:0];
                        next_skip_pend = sum[4] & ~after_add_with_carry_memory;
                    end
                    CSIE_OP_ADD_CARRY: begin
                        sum             = {1'b0, acc} + {1'b0, mem_rdata_in}
                                          + {4'h0, carry_flag};
                        next_acc        = sum[3:0];
                        next_carry_flag = sum[4];
                        next_skip_pend  = sum[4];
                        next_after_add_with_carry_memory = 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Register everything; enable low freezes all state
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            acc        <= `CSIE_NIB_ZERO;
            wide_hi    <= `CSIE_NIB_ZERO;
            ptr        <= `CSIE_PTR_RST;
            carry_flag <= 1'b0;
            skip_pend  <= 1'b0;
            after_add_with_carry_memory <= 1'b0;
            mem_we     <= 1'b0;
            mem_wdata  <= `CSIE_NIB_ZERO;
            last_addr  <= `CSIE_ADDR_RST;
            chain      <= CSIE_CH_NONE;
        end else if (clk_en_in) begin
            acc        <= next_acc;
            wide_hi    <= next_wide_hi;
            ptr        <= next_ptr;
            carry_flag <= next_carry_flag;
            skip_pend  <= next_skip_pend;
            after_add_with_carry_memory <= next_after_add_with_carry_memory;
            mem_we     <= next_mem_we;
            mem_wdata  <= next_mem_wdata;
            last_addr  <= next_last_addr;
            chain      <= next_chain;
        end
    end

    assign acc_out               = acc;
    assign wide_hi_out           = wide_hi;
    assign data_pointer_pair_out = ptr;
    assign carry_flag_out        = carry_flag;
    assign mem_we_out            = mem_we;
    assign mem_wdata_out         = mem_wdata;
    // Current slot is squashed: skip or chained load
    assign skip_out              = skip_pend;
    assign nop_out               = op_valid_in & (skip_pend | in_chain);

    // One clock domain, so clock and reset are given once for every check
    default clocking cb_core @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Carry from add-with-carry squashes exactly the next op
    sequence s_add_with_carry_memory_carry;
        op_valid_in && clk_en_in && !skip_pend && op_in == CSIE_OP_ADD_CARRY
            && next_carry_flag;
    endsequence
    a_add_with_carry_memory_skip_next: assert property (s_add_with_carry_memory_carry |=> skip_pend)
        else $error("carry did not skip next op");
    a_add_with_carry_memory_no_skip: assert property (
        (op_valid_in && clk_en_in && !skip_pend && op_in == CSIE_OP_ADD_CARRY
         && !next_carry_flag) |=> !skip_pend) else $error("skip without carry");
    a_add_immediate_with_skip_suppress: assert property (
        (op_valid_in && clk_en_in && !skip_pend && op_in == CSIE_OP_ADD_SKIP && after_add_with_carry_memory)
        |=> !skip_pend) else $error("correcting add skipped");
    a_carry_kept: assert property (
        (clk_en_in && op_in == CSIE_OP_ADD_SKIP) |=> $stable(carry_flag))
        else $error("immediate add touched carry");
    a_skip_one_cycle: assert property (
        (skip_pend && op_valid_in && clk_en_in) |=> !skip_pend)
        else $error("skip lasted more than one cycle");
    a_chain_nop: assert property (
        (clk_en_in && op_valid_in && in_chain && !skip_pend && op_in == CSIE_OP_LOAD_PTR)
        |=> $stable(ptr)) else $error("chained load took effect");
    a_tclr_clears: assert property (
        (clk_en_in && op_valid_in && !skip_pend && op_in == CSIE_OP_SKIP_TCLR)
        |=> mem_we && !mem_wdata[$past(bit_sel_in)] && skip_pend == $past(bitv))
        else $error("test-and-clear wrong");
    a_bit_set: assert property (
        (clk_en_in && op_valid_in && !skip_pend && op_in == CSIE_OP_BIT_SET)
        |=> mem_we && mem_wdata[$past(bit_sel_in)]) else $error("bit set failed");
    // Skipped slot must leave acc, carry, pointer and memory untouched
    a_skip_no_effect: assert property (
        (skip_pend && op_valid_in && clk_en_in)
        |=> !mem_we && $stable(acc) && $stable(carry_flag) && $stable(ptr))
        else $error("skipped op took effect");
    // Accumulator chain members touch neither nibble
    a_chain_acc_nop: assert property (
        (clk_en_in && op_valid_in && in_chain && !skip_pend
         && (op_in == CSIE_OP_LOAD_ACC || op_in == CSIE_OP_LOAD_WIDE))
        |=> $stable(acc) && $stable(wide_hi)) else $error("chained acc load took effect");
    // The first pointer load of a chain does land
    a_first_ptr_load: assert property (
        (clk_en_in && op_valid_in && !in_chain && !skip_pend && op_in == CSIE_OP_LOAD_PTR)
        |=> ptr == $past(imm_in)) else $error("first pointer load lost");
endmodule // csie_core

//--- test/tb_top.sv
// Self-checking bench for the special instruction unit, with a reference model.
// Assumes csie_pkg is compiled first; the bench drives all inputs at the falling edge.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csie_pkg::*;
    logic        ref_clk_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1, op_valid_in = 1'b0;
    csie_op_e    op_in = CSIE_OP_NONE;
    logic [11:0] op_addr_in = 12'h000, pa;
    logic [1:0]  bit_sel_in = 2'h0;
    logic [7:0]  imm_in = 8'h00, data_pointer_pair_out, m_dp;
    logic [3:0]  mem_rdata_in = 4'h0, mem_wdata_out, acc_out, wide_hi_out, m_acc, m_wh, m_wd;
    logic        mem_we_out, carry_flag_out, skip_out, nop_out;
    logic        m_cy, m_sk, m_we, m_wec, m_add_with_carry_memory;
    csie_chain_e pg;
    int          fails = 0, total_checks = 0;

    // Clock of 100 ns period
    always #50 ref_clk_in = ~ref_clk_in;

    csie_core i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .op_valid_in(op_valid_in), .op_in(op_in), .op_addr_in(op_addr_in),
        .bit_sel_in(bit_sel_in), .imm_in(imm_in), .mem_rdata_in(mem_rdata_in),
        .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .acc_out(acc_out),
        .wide_hi_out(wide_hi_out), .data_pointer_pair_out(data_pointer_pair_out),
        .carry_flag_out(carry_flag_out), .skip_out(skip_out), .nop_out(nop_out));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Loads of one group share a chain; anything else breaks it
    function automatic csie_chain_e grp(input csie_op_e o);
        if (o == CSIE_OP_LOAD_ACC || o == CSIE_OP_LOAD_WIDE) return CSIE_CH_ACC;
        if (o == CSIE_OP_LOAD_PTR) return CSIE_CH_PTR;
        return CSIE_CH_NONE;
    endfunction

    // Compare last cycle's results, present one slot, then advance the model
    task automatic run_op(input csie_op_e o, input logic [11:0] a, input logic [1:0] b,
                          input logic [7:0] im, input logic [3:0] md, input logic v, en);
        logic [4:0] s;
        logic nx, nsk, bt;
        @(negedge ref_clk_in);
        chk(acc_out, m_acc);
        chk(wide_hi_out, m_wh);
        chk(data_pointer_pair_out, m_dp);
        chk(carry_flag_out, m_cy);
        chk(skip_out, m_sk);
        if (m_wec) chk(mem_we_out, m_we);
        if (m_wec && m_we) chk(mem_wdata_out, m_wd);
        op_valid_in = v; op_in = o; op_addr_in = a; bit_sel_in = b; imm_in = im;
        mem_rdata_in = md; clk_en_in = en;
        #1;
        bt = md[b];
        m_wec = en;
        m_we = 1'b0;
        if (en && v) begin
            nx = m_sk || (grp(o) != CSIE_CH_NONE && grp(o) == pg && a == pa + 12'h001);
            chk(nop_out, nx);
            pg = m_sk ? CSIE_CH_NONE : grp(o);
            pa = a;
            nsk = 1'b0;
            if (!nx) case (o)
                CSIE_OP_BIT_SET: begin m_we = 1'b1; m_wd = md | (4'h1 << b); end
                CSIE_OP_BIT_CLEAR: begin m_we = 1'b1; m_wd = md & ~(4'h1 << b); end
                CSIE_OP_SKIP_TRUE: nsk = bt;
                CSIE_OP_SKIP_FALSE: nsk = !bt;
                // The tested bit is always written back cleared, set or not
                CSIE_OP_SKIP_TCLR: begin nsk = bt; m_we = 1'b1; m_wd = md & ~(4'h1 << b); end
                CSIE_OP_CARRY_AND: m_cy = m_cy & bt;
                CSIE_OP_CARRY_OR: m_cy = m_cy | bt;
                CSIE_OP_CARRY_XOR: m_cy = m_cy ^ bt;
                CSIE_OP_LOAD_ACC: m_acc = im[3:0];
                CSIE_OP_LOAD_WIDE: {m_wh, m_acc} = im;
                CSIE_OP_LOAD_PTR: m_dp = im;
                CSIE_OP_ADD_SKIP: begin
                    s = {1'b0, m_acc} + {1'b0, im[3:0]};
                    m_acc = s[3:0];
                    nsk = s[4] && !m_add_with_carry_memory;
                end
                CSIE_OP_ADD_CARRY: begin
                    s = {1'b0, m_acc} + {1'b0, md} + {4'h0, m_cy};
                    {m_cy, m_acc} = s;
                    nsk = s[4];
                end
                default: ;
            endcase
            m_add_with_carry_memory = !nx && o == CSIE_OP_ADD_CARRY;
            m_sk = nsk;
        end
    endtask

    task automatic op(input csie_op_e o, input logic [11:0] a, input logic [7:0] im,
                      input logic [3:0] md);
        run_op(o, a, 2'h0, im, md, 1'b1, 1'b1);
    endtask

    // Reset for 8 cycles; the model clears with it
    task automatic do_reset;
        @(negedge ref_clk_in);
        reset_n_in = 1'b0; op_valid_in = 1'b0; clk_en_in = 1'b1;
        repeat (8) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        {m_acc, m_wh, m_dp, m_cy, m_sk, m_we, m_add_with_carry_memory, pa} = '0;
        m_wec = 1'b1; pg = CSIE_CH_NONE;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #(3000 * 100);
        fails++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h24d3d184));
        do_reset();
        for (int i = 1; i <= 8; i++)
            for (int b = 0; b < 4; b++)
                run_op(csie_op_e'(i), 12'h010, b[1:0], 8'h00, 4'($urandom), 1'b1, 1'b1);
        $display("test bit ops done");
        op(CSIE_OP_LOAD_ACC, 12'h100, 8'h00, 4'h0);
        op(CSIE_OP_LOAD_ACC, 12'h101, 8'h01, 4'h0);
        op(CSIE_OP_LOAD_WIDE, 12'h102, 8'h07, 4'h0);
        op(CSIE_OP_LOAD_PTR, 12'h103, 8'h5A, 4'h0);
        op(CSIE_OP_LOAD_PTR, 12'h104, 8'hC3, 4'h0);
        $display("test chains done");
        // Decimal correction, with and without the middle carry
        op(CSIE_OP_CARRY_AND, 12'h200, 8'h00, 4'h0);
        op(CSIE_OP_LOAD_ACC, 12'h300, 8'h09, 4'h0);
        op(CSIE_OP_ADD_SKIP, 12'h301, 8'h06, 4'h0);
        op(CSIE_OP_ADD_CARRY, 12'h302, 8'h00, 4'h8);
        op(CSIE_OP_ADD_SKIP, 12'h303, 8'h0A, 4'h0);
        op(CSIE_OP_CARRY_AND, 12'h304, 8'h00, 4'h0);
        op(CSIE_OP_LOAD_ACC, 12'h400, 8'h02, 4'h0);
        op(CSIE_OP_ADD_SKIP, 12'h401, 8'h06, 4'h0);
        op(CSIE_OP_ADD_CARRY, 12'h402, 8'h00, 4'h3);
        op(CSIE_OP_ADD_SKIP, 12'h403, 8'h0A, 4'h0);
        op(CSIE_OP_LOAD_ACC, 12'h500, 8'h0F, 4'h0);
        op(CSIE_OP_ADD_SKIP, 12'h502, 8'h01, 4'h0);
        op(CSIE_OP_OTHER, 12'h503, 8'h00, 4'h0);
        $display("test base correction done");
        for (int i = 0; i < 500; i++) begin
            if (i == 250) do_reset();
            run_op(csie_op_e'(1 + $urandom % 14),
                   ($urandom % 4 != 0) ? pa + 12'h001 : 12'($urandom), 2'($urandom),
                   8'($urandom), 4'($urandom), $urandom % 8 != 0, $urandom % 16 != 0);
        end
        run_op(CSIE_OP_NONE, 12'h000, 2'h0, 8'h00, 4'h0, 1'b0, 1'b1);
        $display("test random done");
        end_sim();
    end
endmodule // tb_top
